/* rtl/swfp_pkg.sv */
package swfp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned T_IN_MS    = 250;
  localparam int unsigned IDLE_CYC   = T_IN_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYC  = 200_000;
  localparam int unsigned INT_DIV    = 8;
  localparam int unsigned DLY_STEP   = 32;
  // ----------------------------------------------------------------
  // Register field positions
  // ----------------------------------------------------------------
  localparam int unsigned DUTY_ON_BIT   = 8;
  localparam int unsigned CUR_CSEL_BIT  = 6;
  localparam int unsigned CUR_PRESC_BIT = 7;
  localparam int unsigned CHS_OLOFF_BIT = 6;
  localparam int unsigned CHS_OLON_BIT  = 7;
  localparam int unsigned CHS_OS_BIT    = 8;
  localparam int unsigned GLB_DIRD_LSB  = 0;
  localparam int unsigned GLB_CLKF_BIT  = 2;
  localparam int unsigned GLB_OV_BIT    = 3;
  localparam int unsigned GLB_PWM_LSB   = 7;
  localparam int unsigned ERR_OC = 0, ERR_SC = 1, ERR_OT = 2;
  localparam int unsigned ERR_OS = 3, ERR_OLON = 4, ERR_OLOFF = 5;
  localparam int unsigned ST_UV = 0, ST_OV = 1, ST_CLKF = 2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0]  DUTY_RST = 9'h000;
  localparam logic [8:0]  CHS_RST  = 9'h000;
  localparam logic [1:0]  CUR_RST  = 2'h1;
  localparam logic [15:0] GLB_RST  = 16'h000C;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SWFP_SEL_DUTY = 2'h0,
    SWFP_SEL_CHAN = 2'h1,
    SWFP_SEL_CUR  = 2'h2,
    SWFP_SEL_GLOB = 2'h3
  } swfp_sel_t;
  typedef struct packed {
    logic open_off;
    logic open_on;
    logic short_supply;
    logic overtemperature;
    logic severe_short;
    logic overcurrent;
  } swfp_chf_t;
endpackage : swfp_pkg

/* rtl/swfp_top.sv */
// Function
// - Fault output low while any fault live.
// - Fault bits sticky until register read.
// - Overcurrent, severe short or overtemperature switches channel off; supply faults both.
// - Reset disables short/openload, enables clock/overvoltage.
// - Read clears bit only if gone, unlatched.
// - Fail-safe keeps registers reset, pins control.
// - Fail-safe fault end keeps counter and latches.
// - Latchable fault: off, flag low, bit held.
// - Cause gone before retries end releases flag.
// - Persisting at exhausted retry latches channel off.
// - Flag released only when both channels delatched.
// - Delatch by fault-control 1-0-1 or, with auto-retry on, counter reset.
// - Fault control is active pin or enable bit.
// - Entering fail-safe delatches and resets registers.
// - Faults in fail-safe keep counter and latches.
// - Per-channel PWM; D6 selects internal clock.
// - Duty n gives n+1/256; all ones fully on.
// - Period 256 clocks, or 512 when external and prescaled.
// - Switch-on delay is 32 times field value.
// - Pin activity flag drops after idle timeout.
module swfp_top #(
  parameter int unsigned IDLE_CYC  = swfp_pkg::IDLE_CYC,
  parameter int unsigned RETRY_CYC = swfp_pkg::RETRY_CYC
) (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_i,
  // Pins and analog fault detectors
  input  wire logic [1:0]                 in_pin_i,
  input  wire logic                       ext_clk_i,
  input  wire logic                       clk_fail_i,
  input  wire logic                       supply_low_fault_i,
  input  wire logic                       supply_high_fault_i,
  input  wire swfp_pkg::swfp_chf_t [1:0]  ch_fault_i,
  // Mode and retry control
  input  wire logic                       fail_safe_i,
  input  wire logic [1:0]                 retry_en_i,
  input  wire logic [1:0][3:0]            retry_max_i,
  input  wire logic [1:0]                 retry_clr_i,
  // Register access
  input  wire logic                       wr_i,
  input  wire swfp_pkg::swfp_sel_t        wr_sel_i,
  input  wire logic                       wr_ch_i,
  input  wire logic [15:0]                wr_data_i,
  input  wire logic                       rd_i,
  input  wire logic                       rd_err_i,
  input  wire logic                       rd_ch_i,
  // Outputs
  output logic [15:0]                     rd_data_o,
  output logic [1:0]                      hs_on_o,
  output logic [1:0]                      latched_o,
  output logic                            fault_flag_n_o
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SW = 18;
  logic [SW-1:0] s1_r, s2_r;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {ch_fault_i, in_pin_i, ext_clk_i, clk_fail_i,
               supply_low_fault_i, supply_high_fault_i};
      s2_r <= s1_r;
    end
  end
  swfp_pkg::swfp_chf_t [1:0] chf;
  logic [1:0] pin;
  logic ext_s, clkf_s, uv_s, ov_s;
  assign {chf, pin, ext_s, clkf_s, uv_s, ov_s} = s2_r;

  // ----------------------------------------------------------------
  // Configuration registers and clock sources
  // ----------------------------------------------------------------
  logic [1:0][8:0] duty_r, duty_nxt, chs_r, chs_nxt;
  logic [1:0][1:0] cur_r, cur_nxt;
  logic [15:0]     glb_r, glb_nxt;
  logic ext_d_r, ext_d_nxt, fs_d_r, fs_d_nxt;
  logic [7:0] div_r, div_nxt;
  logic int_tick, ext_tick, ov_live, fs_rise;

  assign int_tick = (div_r == 8'(swfp_pkg::INT_DIV - 1));
  assign ext_tick = ext_s & ~ext_d_r;
  assign fs_rise  = fail_safe_i & ~fs_d_r;
  assign ov_live  = ov_s & glb_r[swfp_pkg::GLB_OV_BIT];

  always_comb begin
    duty_nxt  = duty_r;
    chs_nxt   = chs_r;
    cur_nxt   = cur_r;
    glb_nxt   = glb_r;
    ext_d_nxt = ext_s;
    fs_d_nxt  = fail_safe_i;
    div_nxt   = int_tick ? 8'h00 : div_r + 8'h01;
    if (fail_safe_i) begin
      duty_nxt = {2{swfp_pkg::DUTY_RST}};
      chs_nxt  = {2{swfp_pkg::CHS_RST}};
      cur_nxt  = {2{swfp_pkg::CUR_RST}};
      glb_nxt  = swfp_pkg::GLB_RST;
    end else if (wr_i) begin
      case (wr_sel_i)
        swfp_pkg::SWFP_SEL_DUTY: duty_nxt[wr_ch_i] = wr_data_i[8:0];
        swfp_pkg::SWFP_SEL_CHAN: chs_nxt[wr_ch_i]  = wr_data_i[8:0];
        swfp_pkg::SWFP_SEL_CUR:  cur_nxt[wr_ch_i]  = wr_data_i[7:6];
        swfp_pkg::SWFP_SEL_GLOB: glb_nxt           = wr_data_i;
        default: glb_nxt = glb_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      duty_r  <= {2{swfp_pkg::DUTY_RST}};
      chs_r   <= {2{swfp_pkg::CHS_RST}};
      cur_r   <= {2{swfp_pkg::CUR_RST}};
      glb_r   <= swfp_pkg::GLB_RST;
      ext_d_r <= 1'b0;
      fs_d_r  <= 1'b0;
      div_r   <= 8'h00;
    end else begin
      duty_r  <= duty_nxt;
      chs_r   <= chs_nxt;
      cur_r   <= cur_nxt;
      glb_r   <= glb_nxt;
      ext_d_r <= ext_d_nxt;
      fs_d_r  <= fs_d_nxt;
      div_r   <= div_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel fault, retry and PWM logic
  // ----------------------------------------------------------------
  logic [1:0] live, lat_r, hs_r, pwm_fail;
  logic [1:0][5:0] err_r;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [31:0] idle_r, idle_nxt, tmr_r, tmr_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [8:0]  ph_r, ph_nxt;
    logic [7:0]  dly_r, dly_nxt, ph8;
    logic [5:0]  err_nxt, evt, clr;
    logic pin_d_r, off_r, off_nxt, lat_nxt, blk_r, blk_nxt;
    logic fc_d_r, fcl_r, fcl_nxt, run_r, run_nxt, hs_nxt;
    logic in_on, fc, lf, dl, pwm_en, csel, tick, pwm_out, hson, rd_hit;

    assign in_on  = (idle_r != 32'h0);
    assign fc     = (in_on & ~glb_r[swfp_pkg::GLB_DIRD_LSB+i])
                  | duty_r[i][swfp_pkg::DUTY_ON_BIT];
    assign lf     = chf[i].overcurrent | chf[i].severe_short
                  | chf[i].overtemperature | uv_s;
    assign dl     = (fc & ~fc_d_r & fcl_r)
                  | (retry_clr_i[i] & retry_en_i[i]) | fs_rise;
    assign pwm_en = glb_r[swfp_pkg::GLB_PWM_LSB+i];
    assign csel   = cur_r[i][0];
    assign pwm_fail[i] = pwm_en & ~csel & clkf_s & glb_r[swfp_pkg::GLB_CLKF_BIT];
    assign tick   = csel ? int_tick : ext_tick;
    // Prescaling halves the phase rate, so a period spans 512 ticks.
    assign ph8    = (~csel & cur_r[i][1]) ? ph_r[8:1] : ph_r[7:0];
    assign pwm_out = run_r & ((duty_r[i][7:0] == 8'hFF)
                   | (ph8 <= duty_r[i][7:0]));
    assign hson   = (pin[i] & ~glb_r[swfp_pkg::GLB_DIRD_LSB+i])
                  | (duty_r[i][swfp_pkg::DUTY_ON_BIT]
                     & (~pwm_en | pwm_fail[i] | pwm_out));
    assign evt    = {chf[i].open_off & chs_r[i][swfp_pkg::CHS_OLOFF_BIT],
                     chf[i].open_on & chs_r[i][swfp_pkg::CHS_OLON_BIT],
                     chf[i].short_supply & chs_r[i][swfp_pkg::CHS_OS_BIT],
                     chf[i].overtemperature, chf[i].severe_short,
                     chf[i].overcurrent};
    assign live[i] = |evt;
    assign rd_hit = rd_i & rd_err_i & (rd_ch_i == 1'(i)) & ~fail_safe_i;
    // Latchable bits stay until the retry turn-on and while latched.
    assign clr    = {6{rd_hit}} & ~evt & {3'b111, {3{~lat_r[i] & ~blk_r}}};

    always_comb begin
      idle_nxt = (pin[i] != pin_d_r) ? IDLE_CYC
               : (idle_r != 32'h0) ? idle_r - 32'h1 : 32'h0;
      off_nxt  = off_r;
      lat_nxt  = lat_r[i];
      blk_nxt  = blk_r;
      tmr_nxt  = tmr_r;
      cnt_nxt  = cnt_r;
      fcl_nxt  = fcl_r | (lat_r[i] & ~fc);
      if (lf & ~off_r & ~lat_r[i]) begin
        off_nxt = 1'b1;
        blk_nxt = 1'b1;
        tmr_nxt = RETRY_CYC;
      end else if (off_r & ~lat_r[i]) begin
        // Without auto-retry the channel counts as having no retries left, so it can latch.
        if (tmr_r != 32'h0) begin
          tmr_nxt = tmr_r - 32'h1;
        end else if ((~retry_en_i[i] || cnt_r >= retry_max_i[i]) && lf) begin
          lat_nxt = 1'b1;
        end else begin
          off_nxt = 1'b0;
          blk_nxt = 1'b0;
          cnt_nxt = (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
        end
      end
      // In fail-safe only an explicit sequence delatches, never a new fault.
      if (dl) begin
        lat_nxt = 1'b0;
        off_nxt = 1'b0;
        blk_nxt = 1'b0;
        fcl_nxt = 1'b0;
        cnt_nxt = fs_rise ? cnt_r : 4'h0;
      end
      err_nxt = evt | (err_r[i] & ~clr);
      if (~pwm_en) begin
        run_nxt = 1'b0;
        ph_nxt  = 9'h000;
        dly_nxt = 8'(chs_r[i][2:0] * swfp_pkg::DLY_STEP);
      end else begin
        run_nxt = run_r | (dly_r == 8'h00);
        ph_nxt  = (run_r & tick) ? ph_r + 9'h001 : ph_r;
        dly_nxt = (tick & dly_r != 8'h00) ? dly_r - 8'h01 : dly_r;
      end
      hs_nxt = hson & ~off_r & ~lat_r[i] & ~uv_s & ~ov_live
             & ~chf[i].overcurrent & ~chf[i].severe_short
             & ~chf[i].overtemperature;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        idle_r   <= 32'h0;
        pin_d_r  <= 1'b0;
        off_r    <= 1'b0;
        lat_r[i] <= 1'b0;
        blk_r    <= 1'b0;
        tmr_r    <= 32'h0;
        cnt_r    <= 4'h0;
        fc_d_r   <= 1'b0;
        fcl_r    <= 1'b0;
        err_r[i] <= 6'h00;
        run_r    <= 1'b0;
        ph_r     <= 9'h000;
        dly_r    <= 8'h00;
        hs_r[i]  <= 1'b0;
      end else begin
        idle_r   <= idle_nxt;
        pin_d_r  <= pin[i];
        off_r    <= off_nxt;
        lat_r[i] <= lat_nxt;
        blk_r    <= blk_nxt;
        tmr_r    <= tmr_nxt;
        cnt_r    <= cnt_nxt;
        fc_d_r   <= fc;
        fcl_r    <= fcl_nxt;
        err_r[i] <= err_nxt;
        run_r    <= run_nxt;
        ph_r     <= ph_nxt;
        dly_r    <= dly_nxt;
        hs_r[i]  <= hs_nxt;
      end
    end

    sticky_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      err_r[i][0] && !rd_hit |=> err_r[i][0]) else $error("fault bit lost");
    latch_keep_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      lat_r[i] && err_r[i][0] && !dl |=> err_r[i][0]) else $error("latched bit cleared");
    delatch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      dl |=> !lat_r[i]) else $error("delatch ignored");
    supply_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      uv_s |=> !hs_on_o[i]) else $error("channel on under supply fault");
    delay_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !pwm_en && chs_r[i][2:0] != 3'h0 ##1 pwm_en |-> !run_r ##1 !run_r)
      else $error("switch-on delay skipped");
    full_on_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      run_r && duty_r[i] == 9'h1FF && !off_r && !lat_r[i] && !lf && !ov_live
      |=> hs_on_o[i]) else $error("full duty not on");
    latch_cv: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(lat_r[i]));
    delatch_cv: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      lat_r[i] ##1 !lat_r[i]);
    pwm_cv: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(pwm_out) ##[1:600] $fell(pwm_out));
  end

  // ----------------------------------------------------------------
  // Global status, fault flag and read port
  // ----------------------------------------------------------------
  logic [2:0]  st_r, st_nxt, st_evt, st_clr;
  logic [15:0] rd_r, rd_nxt;
  logic        flag_r, flag_nxt;

  assign st_evt = {|pwm_fail, ov_live, uv_s};
  assign st_clr = {3{rd_i & ~rd_err_i & ~fail_safe_i}} & ~st_evt
                & {2'b11, ~|lat_r};

  always_comb begin
    st_nxt   = st_evt | (st_r & ~st_clr);
    // Latches hold the flag low so it rises only with both delatched.
    flag_nxt = ~(|live | |st_evt | |lat_r);
    rd_nxt   = rd_r;
    if (rd_i) begin
      rd_nxt = fail_safe_i ? 16'h0000
             : rd_err_i ? {10'h000, err_r[rd_ch_i]} : {13'h0000, st_r};
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r   <= 3'h0;
      flag_r <= 1'b1;
      rd_r   <= 16'h0000;
    end else begin
      st_r   <= st_nxt;
      flag_r <= flag_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign rd_data_o      = rd_r;
  assign hs_on_o        = hs_r;
  assign latched_o      = lat_r;
  assign fault_flag_n_o = flag_r;

  flag_live_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    |live |=> !fault_flag_n_o) else $error("fault flag not low");
  fs_reset_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fail_safe_i |=> duty_r == {2{swfp_pkg::DUTY_RST}} && glb_r == swfp_pkg::GLB_RST)
    else $error("registers not reset in fail-safe");
  fs_delatch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fs_rise |=> lat_r == 2'b00) else $error("fail-safe entry kept latch");
endmodule : swfp_top

/* tb/swfp_host_model.sv */
module swfp_host_model #(
  parameter int unsigned IDLE_CYC = 200
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // Requests from the bench
  input  wire logic [1:0] pin_req_i,
  input  wire logic       ext_run_i,
  // Pins towards the switch
  output logic      [1:0] in_pin_o,
  output logic            ext_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned low_cnt_r [2];
  logic [2:0]  div_r;
  // The clock pin stands still while the bench keeps it idle.
  assign ext_clk_o = ext_run_i & div_r[2];
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_pin_o <= 2'h0;
      div_r    <= 3'h0;
      low_cnt_r <= '{0, 0};
    end else begin
      div_r <= div_r + 3'h1;
      for (int c = 0; c < 2; c++) begin
        // A pin that went low stays low for the idle time before it rises again.
        if (!in_pin_o[c] && low_cnt_r[c] <= IDLE_CYC + 2) begin
          low_cnt_r[c] <= low_cnt_r[c] + 1;
        end
        if (!pin_req_i[c]) begin
          in_pin_o[c]  <= 1'b0;
          low_cnt_r[c] <= 0;
        end else if (in_pin_o[c] || low_cnt_r[c] > IDLE_CYC + 2) begin
          in_pin_o[c] <= 1'b1;
        end
      end
    end
  end
endmodule : swfp_host_model

/* tb/swfp_top_tb.sv */
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module swfp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           sys_clk_i = 1'b0;
  logic                           reset_i = 1'b1;
  logic [1:0]                     pin_req = 2'h0;
  logic                           ext_run = 1'b0;
  logic [1:0]                     in_pin;
  logic                           ext_clk;
  logic                           clk_fail_i = 1'b0;
  logic                           low_f = 1'b0;
  logic                           high_f = 1'b0;
  swfp_pkg::swfp_chf_t [1:0]      chf = '0;
  logic                           fail_safe_i = 1'b0;
  logic [1:0]                     retry_en = 2'h0;
  logic [1:0][3:0]                retry_max = '0;
  logic [1:0]                     retry_clr = 2'h0;
  logic                           wr_i = 1'b0;
  swfp_pkg::swfp_sel_t            wr_sel = swfp_pkg::SWFP_SEL_DUTY;
  logic                           wr_ch = 1'b0;
  logic [15:0]                    wr_data = 16'h0000;
  logic                           rd_i = 1'b0;
  logic                           rd_err = 1'b0;
  logic                           rd_ch = 1'b0;
  logic [15:0]                    rd_data_o;
  logic [1:0]                     hs_on_o;
  logic [1:0]                     latched_o;
  logic                           fault_flag_n_o;
  int                             num_errors = 0;
  int                             compares = 0;
  logic [15:0]                    rv;
  logic [7:0]                     seed = 8'h4C;
  int                             n;
  always #2.5 sys_clk_i = ~sys_clk_i;
  swfp_host_model #(.IDLE_CYC(200)) u_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .pin_req_i(pin_req), .ext_run_i(ext_run), .in_pin_o(in_pin), .ext_clk_o(ext_clk));
  swfp_top #(.IDLE_CYC(200), .RETRY_CYC(20)) u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .in_pin_i(in_pin), .ext_clk_i(ext_clk), .clk_fail_i(clk_fail_i),
    .supply_low_fault_i(low_f), .supply_high_fault_i(high_f), .ch_fault_i(chf),
    .fail_safe_i(fail_safe_i), .retry_en_i(retry_en), .retry_max_i(retry_max),
    .retry_clr_i(retry_clr), .wr_i(wr_i), .wr_sel_i(wr_sel), .wr_ch_i(wr_ch),
    .wr_data_i(wr_data), .rd_i(rd_i), .rd_err_i(rd_err), .rd_ch_i(rd_ch),
    .rd_data_o(rd_data_o), .hs_on_o(hs_on_o), .latched_o(latched_o),
    .fault_flag_n_o(fault_flag_n_o));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic wr(input swfp_pkg::swfp_sel_t s, input logic c, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1; wr_sel <= s; wr_ch <= c; wr_data <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic e, input logic c);
    @(posedge sys_clk_i);
    rd_i <= 1'b1; rd_err <= e; rd_ch <= c;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rv = rd_data_o;
  endtask : rd
  task automatic wt(input int c);
    repeat (c) @(negedge sys_clk_i);
  endtask : wt
  // One whole phase period, eight cycles a tick: any window that long sees all of the on-time.
  task automatic pwm_chk(input logic [8:0] d, input int per);
    int exp;
    wr(swfp_pkg::SWFP_SEL_DUTY, 1'b0, {7'h00, d});
    wr(swfp_pkg::SWFP_SEL_GLOB, 1'b0, 16'h008C);
    wt(2200);
    n = 0;
    repeat (per) begin @(negedge sys_clk_i); n += int'(hs_on_o[0] === 1'b1); end
    exp = !d[8] ? 0 : (d[7:0] == 8'hFF) ? per : (int'(d[7:0]) + 1) * (per / 256);
    `CHK("pwm_on", exp, n);
    wr(swfp_pkg::SWFP_SEL_GLOB, 1'b0, 16'h000C);
  endtask : pwm_chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    #(5.0 * 60000);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    // Detections that are off after reset must not pull the flag.
    @(posedge sys_clk_i);
    chf[0].open_off <= 1'b1; chf[0].open_on <= 1'b1; chf[1].short_supply <= 1'b1;
    wt(10);
    `CHK("flag_rst", 1'b1, fault_flag_n_o);
    @(posedge sys_clk_i);
    chf <= '0;
    $display("test reset done");
    // Duty codes: corners plus random ones, internal then external clock.
    pwm_chk(9'h000, 2048);
    pwm_chk(9'h100, 2048);
    pwm_chk(9'h1FF, 2048);
    repeat (2) begin seed = lfsr(seed); pwm_chk({1'b1, seed}, 2048); end
    wr(swfp_pkg::SWFP_SEL_CUR, 1'b0, 16'h0000);
    ext_run <= 1'b1;
    seed = lfsr(seed);
    pwm_chk({1'b1, seed}, 2048);
    // The prescaler doubles the period to 512 ticks in external mode.
    wr(swfp_pkg::SWFP_SEL_CUR, 1'b0, 16'h0080);
    seed = lfsr(seed);
    pwm_chk({1'b1, seed}, 4096);
    // A failed external clock leaves the channel on as its enable bit says.
    wr(swfp_pkg::SWFP_SEL_GLOB, 1'b0, 16'h008C);
    clk_fail_i <= 1'b1;
    wt(5);
    `CHK("clkf_flag", 1'b0, fault_flag_n_o);
    `CHK("clkf_on", 1'b1, hs_on_o[0]);
    @(posedge sys_clk_i);
    clk_fail_i <= 1'b0;
    wt(5);
    `CHK("clkf_rel", 1'b1, fault_flag_n_o);
    rd(1'b0, 1'b0); `CHK("clkf_bit", 1'b1, rv[2]);
    rd(1'b0, 1'b0); `CHK("clkf_clr", 1'b0, rv[2]);
    wr(swfp_pkg::SWFP_SEL_GLOB, 1'b0, 16'h000C);
    ext_run <= 1'b0;
    wr(swfp_pkg::SWFP_SEL_CUR, 1'b0, 16'h0040);
    $display("test pwm done");
    // Switch-on delay of one step: 32 ticks of eight cycles.
    wr(swfp_pkg::SWFP_SEL_CHAN, 1'b0, 16'h0001);
    wr(swfp_pkg::SWFP_SEL_DUTY, 1'b0, 16'h0180);
    wr(swfp_pkg::SWFP_SEL_GLOB, 1'b0, 16'h008C);
    // The channel stays fully on for two cycles until the enable takes hold.
    wt(2);
    n = 0;
    while (hs_on_o[0] !== 1'b1 && n < 400) begin @(negedge sys_clk_i); n++; end
    `CHK("delay_win", 1'b1, n >= 240 && n <= 300);
    wr(swfp_pkg::SWFP_SEL_GLOB, 1'b0, 16'h000C);
    wr(swfp_pkg::SWFP_SEL_DUTY, 1'b1, 16'h0100);
    $display("test delay done");
    // Overvoltage is not latchable: bit sticks until read after the cause has gone.
    high_f <= 1'b1;
    wt(5);
    `CHK("ov_flag", 1'b0, fault_flag_n_o);
    `CHK("ov_off", 2'h0, hs_on_o);
    rd(1'b0, 1'b0); `CHK("ov_bit", 1'b1, rv[1]);
    rd(1'b0, 1'b0); `CHK("ov_keep", 1'b1, rv[1]);
    @(posedge sys_clk_i);
    high_f <= 1'b0;
    wt(5);
    `CHK("ov_rel", 1'b1, fault_flag_n_o);
    rd(1'b0, 1'b0); `CHK("ov_sticky", 1'b1, rv[1]);
    rd(1'b0, 1'b0); `CHK("ov_clr", 1'b0, rv[1]);
    $display("test supply done");
    // Short overcurrent with retries left: flag comes back, bit stays.
    @(posedge sys_clk_i);
    retry_en <= 2'h1; retry_max[0] <= 4'h3;
    chf[0].overcurrent <= 1'b1;
    wt(10);
    `CHK("oc_flag", 1'b0, fault_flag_n_o);
    @(posedge sys_clk_i);
    chf[0].overcurrent <= 1'b0;
    wt(60);
    `CHK("retry_rel", 1'b1, fault_flag_n_o);
    `CHK("retry_nolat", 1'b0, latched_o[0]);
    rd(1'b1, 1'b0); `CHK("retry_bit", 1'b1, rv[0]);
    $display("test retry done");
    // No retries allowed: the persisting overcurrent latches the channel.
    @(posedge sys_clk_i);
    retry_en <= 2'h0; retry_max[0] <= 4'h0;
    chf[0].overcurrent <= 1'b1;
    wt(5);
    `CHK("oc_off", 1'b0, hs_on_o[0]);
    `CHK("oc_other", 1'b1, hs_on_o[1]);
    wt(40);
    @(posedge sys_clk_i);
    chf[0].overcurrent <= 1'b0;
    wt(40);
    `CHK("lat", 1'b1, latched_o[0]);
    `CHK("lat_flag", 1'b0, fault_flag_n_o);
    rd(1'b1, 1'b0); rd(1'b1, 1'b0); `CHK("lat_bit", 1'b1, rv[0]);
    wr(swfp_pkg::SWFP_SEL_DUTY, 1'b0, 16'h0000);
    wr(swfp_pkg::SWFP_SEL_DUTY, 1'b0, 16'h0100);
    wt(10);
    `CHK("delat", 1'b0, latched_o[0]);
    `CHK("delat_flag", 1'b1, fault_flag_n_o);
    `CHK("delat_on", 1'b1, hs_on_o[0]);
    $display("test latch done");
    // Latch again, then fail-safe entry delatches and locks the registers.
    @(posedge sys_clk_i);
    chf[0].overcurrent <= 1'b1;
    wt(80);
    `CHK("lat_again", 1'b1, latched_o[0]);
    // A counter reset delatches only while auto-retry is on.
    @(posedge sys_clk_i);
    retry_clr <= 2'h1;
    @(posedge sys_clk_i);
    retry_clr <= 2'h0;
    wt(3);
    `CHK("clr_noretry", 1'b1, latched_o[0]);
    @(posedge sys_clk_i);
    retry_en <= 2'h1;
    retry_clr <= 2'h1;
    @(posedge sys_clk_i);
    retry_clr <= 2'h0;
    wt(3);
    `CHK("clr_delat", 1'b0, latched_o[0]);
    wt(80);
    `CHK("lat2", 1'b1, latched_o[0]);
    @(posedge sys_clk_i);
    chf[0].overcurrent <= 1'b0;
    fail_safe_i <= 1'b1;
    wt(5);
    `CHK("fs_delat", 1'b0, latched_o[0]);
    `CHK("fs_regs", 2'h0, hs_on_o);
    wr(swfp_pkg::SWFP_SEL_DUTY, 1'b1, 16'h0100);
    wt(5);
    `CHK("fs_wr", 1'b0, hs_on_o[1]);
    rd(1'b1, 1'b0); `CHK("fs_rd", 16'h0000, rv);
    @(posedge sys_clk_i);
    pin_req <= 2'h2;
    wt(220);
    `CHK("fs_pin", 1'b1, hs_on_o[1]);
    @(posedge sys_clk_i);
    low_f <= 1'b1;
    wt(5);
    `CHK("fs_uv", 2'h0, hs_on_o);
    @(posedge sys_clk_i);
    low_f <= 1'b0;
    wt(80);
    `CHK("fs_back", 1'b1, fault_flag_n_o);
    `CHK("fs_resume", 1'b1, hs_on_o[1]);
    @(posedge sys_clk_i);
    pin_req <= 2'h0;
    wt(300);
    @(posedge sys_clk_i);
    fail_safe_i <= 1'b0;
    $display("test failsafe done");
    stop_test();
  end
endmodule : swfp_top_tb
